// ===== src/sopw_regs.svh
// Constants of the single-line programming link: timing, command fields, entry frame.
// Assumes a 20 MHz system clock; included by bare name wherever needed.
`ifndef SOPW_REGS_SVH
`define SOPW_REGS_SVH
// ----------------------------------------
// Timing in printed units
// ----------------------------------------
`define SOPW_CLK_MHZ 20
`define SOPW_START_NS 5000
`define SOPW_STOP_NS 5000
`define SOPW_TIMEOUT_NS 220000
`define SOPW_TURNON_MS 5
`define SOPW_ENTRY_MS 20
`define SOPW_BIT_US 20
`define SOPW_PROG_MS 20
`define SOPW_PUMP_MS 1
// ----------------------------------------
// Timing in clock cycles
// ----------------------------------------
`define SOPW_START_CYC ((`SOPW_START_NS * `SOPW_CLK_MHZ + 999) / 1000)
`define SOPW_STOP_CYC ((`SOPW_STOP_NS * `SOPW_CLK_MHZ + 999) / 1000)
`define SOPW_TIMEOUT_CYC ((`SOPW_TIMEOUT_NS * `SOPW_CLK_MHZ) / 1000)
`define SOPW_TURNON_CYC (`SOPW_TURNON_MS * `SOPW_CLK_MHZ * 1000)
`define SOPW_ENTRY_CYC (`SOPW_ENTRY_MS * `SOPW_CLK_MHZ * 1000)
`define SOPW_BIT_CYC (`SOPW_BIT_US * `SOPW_CLK_MHZ)
`define SOPW_PROG_CYC (`SOPW_PROG_MS * `SOPW_CLK_MHZ * 1000)
`define SOPW_PUMP_CYC (`SOPW_PUMP_MS * `SOPW_CLK_MHZ * 1000)
// ----------------------------------------
// Command byte and frame layout
// ----------------------------------------
`define SOPW_RW_POS 0
`define SOPW_REGION_NVM 3'h0
`define SOPW_REGION_REG 3'h4
`define SOPW_WRITE_BITS 24
`define SOPW_DATA_BITS 16
`define SOPW_ENTRY_CMD 8'h9E
`define SOPW_ENTRY_DATA 16'hA5C3
`endif

// ===== src/sopw_pkg.sv
// Types and command decoding shared by both ends of the programming link.
// Assumes sopw_regs.svh is on the include path.
`default_nettype none
`include "sopw_regs.svh"
package sopw_pkg;
  typedef logic [7:0] sopw_cmd_t;
  typedef logic [15:0] sopw_word_t;
  typedef enum logic [2:0] {SL_IDLE, SL_RX, SL_TKO, SL_TX, SL_WSTOP, SL_DEAF, SL_PUSH} sopw_slv_state_t;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BITS, MS_STOP} sopw_mst_state_t;

  // Region of a command byte is memory or register space
  function automatic logic sopw_region_ok(input sopw_cmd_t c);
    return (c[7:5] == `SOPW_REGION_NVM) || (c[7:5] == `SOPW_REGION_REG);
  endfunction

  // Command byte addresses the memory region
  function automatic logic sopw_is_nvm(input sopw_cmd_t c);
    return c[7:5] == `SOPW_REGION_NVM;
  endfunction
endpackage
`default_nettype wire

// ===== src/sopw_link_if.sv
// One channel's shared data line between programming master and sensor channel.
// Assumes a pull-up: the line is low while either driving party drives low.
`timescale 1ns/1ps
`default_nettype none
interface sopw_link_if;
  logic m_drv;
  logic m_oe;
  logic s_drv;
  logic s_oe;
  logic line;
  // Wired resolution of both drivers with pull-up
  assign line = ~((m_oe & ~m_drv) | (s_oe & ~s_drv));
  modport host (input line, output m_drv, output m_oe);
  modport device (input line, output s_drv, output s_oe);
endinterface
`default_nettype wire

// ===== src/sopw_buf.sv
// Small valid/ready buffer of flip-flops, width and depth set by parameters.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sopw_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic [AW:0] next_count;

  // Pointer step with wrap at depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Handshake and occupancy
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rp];
  assign next_count = push == pop ? count : (push ? count + 1'b1 : count - 1'b1);

  // Storage and pointers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end
    else
    begin
      count <= next_count;
      if (push)
      begin
        mem[wp] <= in_data;
        wp <= bump(wp);
      end
      if (pop)
        rp <= bump(rp);
    end
  end
endmodule
`default_nettype wire

// ===== src/sopw_slave.sv
// One sensor channel's programming slave on its shared output/data line.
// Assumes the line input is synchronous to CLK_SYS and RST is the power-on reset.
//
// What this block does
// - Analog output after turn-on unless command mode
// - Entry frame accepted only inside entry window
// - Each channel accepts entry on its own
// - Master starts every transfer; slave only answers
// - Frame: idle, start, command, two bytes, stop
// - Master start: long low then rising edge
// - Write data bytes directly follow the command byte
// - Reads insert handover bits around data bytes
// - Master ends frames with stop, then high
// - No rising edge past time-out resets receiver
// - Entry sequence uses the ordinary frame
// - Command mode reaches memory and registers
// - Command mode left only by power-on reset
// - Long high is one, short high zero
// - Master waits pump settle before memory writes
// - Master rewrites checksum after memory changes; sopw_master has no checksum step
// - Command mode turns pin into data line
// - Command byte: region, address, read/write, MSB first
// - Bit period between 10 and 100 us
// - Handover: zero bit, release, other side drives low
// - Master waits 20 ms between memory addresses
`timescale 1ns/1ps
`default_nettype none
`include "sopw_regs.svh"
module sopw_slave #(
  parameter int TIMEOUT_CYC = `SOPW_TIMEOUT_CYC,
  parameter int TURNON_CYC = `SOPW_TURNON_CYC,
  parameter int ENTRY_CYC = `SOPW_ENTRY_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  sopw_link_if.device LINK,
  output logic ANALOG_OE,
  output logic CMD_MODE,
  output logic WR_VALID,
  input wire logic WR_READY,
  output sopw_pkg::sopw_cmd_t WR_CMD,
  output sopw_pkg::sopw_word_t WR_DATA,
  output sopw_pkg::sopw_cmd_t RD_CMD,
  input wire sopw_pkg::sopw_word_t RD_DATA
);
  import sopw_pkg::*;

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam int CW = $clog2(TIMEOUT_CYC + 2);
  localparam int AGE_MAX = (TURNON_CYC > ENTRY_CYC) ? TURNON_CYC : ENTRY_CYC;
  localparam int AW = $clog2(AGE_MAX + 1);
  localparam logic [CW-1:0] START_LIM = CW'(`SOPW_START_CYC);
  localparam logic [CW-1:0] TO_LIM = CW'(TIMEOUT_CYC);
  localparam logic [4:0] NB_CMD_LAST = 5'h07;
  localparam logic [4:0] NB_FRAME_LAST = 5'(`SOPW_WRITE_BITS - 1);
  localparam logic [4:0] TXI_HO = 5'(`SOPW_DATA_BITS);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sopw_slv_state_t state;
  logic line_q;
  logic [CW-1:0] cnt;
  logic [CW-1:0] low_cnt;
  logic [CW-1:0] width;
  logic [CW-1:0] per;
  logic [CW-1:0] tcnt;
  logic [4:0] nb;
  logic [4:0] txi;
  logic [23:0] shreg;
  logic [15:0] txd;
  logic [AW-1:0] age;
  logic cmd_mode;
  logic analog_on;
  logic tko_seen;
  logic drv;
  logic oe;
  logic next_drv;
  logic next_oe;
  logic buf_in_ready;
  logic [23:0] buf_out;
  sopw_cmd_t rd_cmd;

  // ----------------------------------------
  // Line decoding
  // ----------------------------------------
  // Edges, time-out and bit value from pulse width against period
  wire rise = LINK.line & ~line_q;
  wire fall = ~LINK.line & line_q;
  wire timeout = (cnt >= TO_LIM);
  wire bit_val = (width > (cnt >> 1));
  wire [23:0] next_frame = {shreg[22:0], bit_val};
  wire rx_edge = (state == SL_RX) & rise;
  wire cmd_done = rx_edge & (nb == NB_CMD_LAST);
  wire frame_done = rx_edge & (nb == NB_FRAME_LAST);
  wire is_read = next_frame[`SOPW_RW_POS];
  wire window_open = (age < AW'(ENTRY_CYC));
  wire ton_done = (age >= AW'(TURNON_CYC));
  wire entry_ok = ~cmd_mode & window_open & (next_frame == {`SOPW_ENTRY_CMD, `SOPW_ENTRY_DATA});
  wire bit_end = (tcnt == per - 1'b1);
  wire [CW-1:0] q1 = per >> 2;
  wire [CW-1:0] q3 = (per >> 1) + (per >> 2);
  wire tx_bit = (txi == TXI_HO) ? 1'b0 : txd[15];

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  // Rise-to-rise count, high width, low length, time since reset
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      line_q <= 1'b1;
      cnt <= '0;
      low_cnt <= '0;
      width <= '0;
      age <= '0;
      analog_on <= 1'b0;
    end
    else
    begin
      line_q <= LINK.line;
      cnt <= rise ? '0 : (timeout ? cnt : cnt + 1'b1);
      low_cnt <= LINK.line ? (line_q ? '0 : low_cnt) : ((low_cnt == START_LIM) ? low_cnt : low_cnt + 1'b1);
      if (fall)
        width <= cnt;
      if (age != AW'(AGE_MAX))
        age <= age + 1'b1;
      analog_on <= ton_done & ~cmd_mode;
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  // Receives frames, answers reads, hands writes to the buffer
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state <= SL_IDLE;
      nb <= '0;
      shreg <= '0;
      per <= '0;
      tcnt <= '0;
      txi <= '0;
      txd <= '0;
      cmd_mode <= 1'b0;
      rd_cmd <= '0;
      tko_seen <= 1'b0;
    end
    else
    begin
      tcnt <= tcnt + 1'b1;
      case (state)
        SL_IDLE:
          if (rise && low_cnt >= START_LIM)
          begin
            state <= SL_RX;
            nb <= '0;
          end
        SL_RX:
          if (timeout)
            state <= SL_IDLE;
          else if (rise)
          begin
            shreg <= next_frame;
            nb <= nb + 1'b1;
            if (cmd_done && is_read)
            begin
              if (cmd_mode && sopw_region_ok(next_frame[7:0]))
              begin
                state <= SL_TKO;
                rd_cmd <= next_frame[7:0];
                per <= cnt + 1'b1;
                tcnt <= '0;
                tko_seen <= 1'b0;
              end
              else
                state <= SL_DEAF;
            end
            else if (frame_done)
            begin
              if (cmd_mode && sopw_region_ok(next_frame[23:16]))
                state <= SL_PUSH;
              else
                state <= SL_IDLE;
              if (entry_ok)
                cmd_mode <= 1'b1;
            end
          end
        SL_TKO:
        begin
          if (fall)
            tko_seen <= 1'b1;
          if (bit_end)
          begin
            state <= SL_TX;
            tcnt <= '0;
            txi <= '0;
            txd <= RD_DATA;
          end
        end
        SL_TX:
          // The stop rise can land on the last slot edge, so it is caught here as well as in SL_WSTOP
          if (rise && (txi == TXI_HO) && (tcnt >= q3))
            state <= SL_IDLE;
          else if (bit_end)
          begin
            tcnt <= '0;
            txi <= txi + 1'b1;
            txd <= {txd[14:0], 1'b0};
            if (txi == TXI_HO)
              state <= SL_WSTOP;
          end
        SL_WSTOP:
          if (timeout || rise)
            state <= SL_IDLE;
        SL_DEAF:
          if (timeout)
            state <= SL_IDLE;
        SL_PUSH:
          if (buf_in_ready)
            state <= SL_IDLE;
        default:
          state <= SL_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Line drive
  // ----------------------------------------
  // Drives only while answering a read in command mode
  always_comb
  begin
    next_oe = 1'b0;
    next_drv = 1'b1;
    case (state)
      SL_TKO:
      begin
        next_oe = tko_seen | fall;
        next_drv = 1'b0;
      end
      SL_TX:
      begin
        next_oe = ~((txi == TXI_HO) && (tcnt >= q3));
        next_drv = tcnt < (tx_bit ? q3 : q1);
      end
      default:
      begin
        next_oe = 1'b0;
        next_drv = 1'b1;
      end
    endcase
  end

  // Registered pin drive
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      oe <= 1'b0;
      drv <= 1'b1;
    end
    else
    begin
      oe <= next_oe;
      drv <= next_drv;
    end
  end

  // ----------------------------------------
  // Write buffer and outputs
  // ----------------------------------------
  sopw_buf #(
    .WIDTH(24),
    .DEPTH(2)
  ) u_buf (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(state == SL_PUSH),
    .in_data(shreg),
    .in_ready(buf_in_ready),
    .out_valid(WR_VALID),
    .out_data(buf_out),
    .out_ready(WR_READY)
  );

  // Port assignments
  assign WR_CMD = buf_out[23:16];
  assign WR_DATA = buf_out[15:0];
  assign RD_CMD = rd_cmd;
  assign ANALOG_OE = analog_on;
  assign CMD_MODE = cmd_mode;
  assign LINK.s_oe = oe;
  assign LINK.s_drv = drv;
endmodule
`default_nettype wire

// ===== src/sopw_master.sv
// Programming master for one channel's shared data line.
// Assumes the line input is synchronous to CLK_SYS; one frame per accepted command.
`timescale 1ns/1ps
`default_nettype none
`include "sopw_regs.svh"
module sopw_master #(
  parameter int BIT_CYC = `SOPW_BIT_CYC,
  parameter int PROG_CYC = `SOPW_PROG_CYC,
  parameter int PUMP_CYC = `SOPW_PUMP_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  sopw_link_if.host LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire sopw_pkg::sopw_cmd_t CMD_BYTE,
  input wire sopw_pkg::sopw_word_t CMD_DATA,
  output logic RSP_VALID,
  output sopw_pkg::sopw_word_t RSP_DATA
);
  import sopw_pkg::*;

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam int SC = `SOPW_START_CYC;
  localparam int STC = `SOPW_STOP_CYC;
  localparam int CW = $clog2(BIT_CYC + SC + STC + 1);
  localparam int HMAX = (PROG_CYC > PUMP_CYC) ? PROG_CYC : PUMP_CYC;
  localparam int HW = $clog2(HMAX + 1);
  localparam logic [CW-1:0] B_END = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] Q1 = CW'(BIT_CYC / 4);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
  localparam logic [CW-1:0] Q3 = CW'((BIT_CYC * 3) / 4);
  localparam logic [CW-1:0] START_END = CW'(SC - 1);
  localparam logic [CW-1:0] STOP_END = CW'(STC - 1);
  localparam logic [4:0] BI_HO = 5'h08;
  localparam logic [4:0] BI_SHO = 5'h19;
  localparam logic [4:0] BI_WLAST = 5'h17;

  sopw_mst_state_t state;
  logic [CW-1:0] tcnt;
  logic [4:0] bi;
  logic [23:0] sh;
  logic [15:0] rx;
  logic [HW-1:0] hold;
  logic rd;
  logic nvm;
  logic oe;
  logic drv;
  logic next_oe;
  logic next_drv;
  logic rsp_valid;
  sopw_word_t rsp_data;

  // ----------------------------------------
  // Bit slot decoding
  // ----------------------------------------
  wire bit_end = (tcnt == B_END);
  wire ho_bit = rd & (bi == BI_HO);
  wire sending = (bi < BI_HO) | (~rd & (bi <= BI_WLAST)) | ho_bit;
  wire tx_bit = ho_bit ? 1'b0 : sh[23];
  wire rx_slot = rd & (bi > BI_HO) & (bi < BI_SHO);
  wire last_bit = bit_end & (bi == (rd ? BI_SHO : BI_WLAST));
  assign CMD_READY = (state == MS_IDLE) & (hold == '0);

  // Pin drive for the current slot
  always_comb
  begin
    next_oe = 1'b0;
    next_drv = 1'b1;
    case (state)
      MS_IDLE, MS_STOP:
        next_oe = 1'b1;
      MS_START:
      begin
        next_oe = 1'b1;
        next_drv = 1'b0;
      end
      MS_BITS:
        if (sending)
        begin
          next_oe = ~(ho_bit && tcnt >= Q3);
          next_drv = tcnt < (tx_bit ? Q3 : Q1);
        end
        else if (rd && bi == BI_SHO)
        begin
          next_oe = (tcnt >= HALF);
          next_drv = 1'b0;
        end
      default:
        next_oe = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state <= MS_IDLE;
      tcnt <= '0;
      bi <= '0;
      sh <= '0;
      rx <= '0;
      hold <= '0;
      rd <= 1'b0;
      nvm <= 1'b0;
      oe <= 1'b0;
      drv <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end
    else
    begin
      oe <= next_oe;
      drv <= next_drv;
      tcnt <= tcnt + 1'b1;
      rsp_valid <= 1'b0;
      if (hold != '0)
        hold <= hold - 1'b1;
      case (state)
        MS_IDLE:
          if (CMD_VALID && CMD_READY)
          begin
            state <= MS_START;
            tcnt <= '0;
            sh <= {CMD_BYTE, CMD_DATA};
            rd <= CMD_BYTE[`SOPW_RW_POS];
            nvm <= sopw_is_nvm(CMD_BYTE);
          end
        MS_START:
          if (tcnt == START_END)
          begin
            state <= MS_BITS;
            tcnt <= '0;
            bi <= '0;
          end
        MS_BITS:
        begin
          if (rx_slot && tcnt == HALF)
            rx <= {rx[14:0], LINK.line};
          if (bit_end)
          begin
            tcnt <= '0;
            bi <= bi + 1'b1;
            sh <= {sh[22:0], 1'b0};
            if (last_bit)
              state <= MS_STOP;
          end
        end
        MS_STOP:
          if (tcnt == STOP_END)
          begin
            state <= MS_IDLE;
            rsp_valid <= rd;
            if (rd)
              rsp_data <= rx;
            else
              hold <= nvm ? HW'(PROG_CYC) : HW'(PUMP_CYC);
          end
        default:
          state <= MS_IDLE;
      endcase
    end
  end

  assign LINK.m_oe = oe;
  assign LINK.m_drv = drv;
  assign RSP_VALID = rsp_valid;
  assign RSP_DATA = rsp_data;
endmodule
`default_nettype wire

// ===== tb/sopw_link_monitor.sv
// Checker of one channel's shared data line, watching both drivers and the wire.
// Assumes the testbench hands it the link signals, CLK_SYS and RST.
`timescale 1ns/1ps
`default_nettype none
module sopw_link_monitor #(
  parameter int BIT_CYC = 40,
  parameter int START_CYC = 100,
  parameter int STOP_CYC = 100
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic m_drv,
  input wire logic m_oe,
  input wire logic s_drv,
  input wire logic s_oe,
  input wire logic line
);
  // ----------------------------------------
  // Run lengths
  // ----------------------------------------
  localparam int Q1 = BIT_CYC / 4;
  localparam int Q3 = (3 * BIT_CYC) / 4;
  logic [15:0] hi_cnt, lo_cnt, mhi_cnt, shi_cnt, soe_cnt;
  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction
  // Count levels; reset counts as a long idle high
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      hi_cnt <= 16'hFFFF;
      lo_cnt <= 16'h0000;
      mhi_cnt <= 16'h0000;
      shi_cnt <= 16'h0000;
      soe_cnt <= 16'h0000;
    end
    else
    begin
      hi_cnt <= line ? inc(hi_cnt) : 16'h0000;
      lo_cnt <= line ? 16'h0000 : inc(lo_cnt);
      mhi_cnt <= (m_oe && m_drv) ? inc(mhi_cnt) : 16'h0000;
      shi_cnt <= (s_oe && s_drv) ? inc(shi_cnt) : 16'h0000;
      soe_cnt <= s_oe ? inc(soe_cnt) : 16'h0000;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb_mon @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // Slave takes the line low, and the wire follows
  sequence s_takeover;
    !s_drv ##1 !line;
  endsequence
  // Master already holds the line low when the slave lets go
  sequence s_giveback;
    m_oe && !m_drv;
  endsequence
  a_no_fight: assert property (!(m_oe && s_oe && (m_drv != s_drv)))
    else $error("both ends drive opposite levels");
  a_slave_takeover: assert property ($rose(s_oe) |-> s_takeover)
    else $error("slave takeover is not a low level");
  a_master_takeback: assert property ($fell(s_oe) |-> s_giveback)
    else $error("slave released before master took over");
  a_start_len: assert property ($rose(line) && (lo_cnt > BIT_CYC) |-> lo_cnt >= START_CYC)
    else $error("start low too short");
  a_stop_len: assert property ($fell(line) && (hi_cnt > BIT_CYC) |-> hi_cnt >= STOP_CYC)
    else $error("stop high too short");
  a_master_width: assert property ($fell(m_drv) && m_oe && (mhi_cnt != 0) && (mhi_cnt < BIT_CYC)
    |-> mhi_cnt inside {[Q1-1:Q1+1], [Q3-1:Q3+1]})
    else $error("master high pulse has a bad width");
  a_slave_width: assert property ($fell(s_drv) && s_oe && (shi_cnt != 0) && (shi_cnt < BIT_CYC)
    |-> shi_cnt inside {[Q1-2:Q1+2], [Q3-2:Q3+2]})
    else $error("slave high pulse has a bad width");
  a_slave_span: assert property (soe_cnt <= 18 * BIT_CYC)
    else $error("slave drives the line too long");
endmodule
`default_nettype wire

// ===== tb/sensor_one_wire_programming_slave_tb_top.sv
// Bench of two programming channels, each a master facing a slave on its own link.
// Assumes the design sources and the link monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sopw_regs.svh"
module sensor_one_wire_programming_slave_tb_top;
  import sopw_pkg::*;
  // ----------------------------------------
  // Clock, reset and channel signals
  // ----------------------------------------
  localparam int BIT = 40;
  localparam int TMO = 600;
  localparam int TON = 50;
  localparam int ENT = 4000;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic cv [2] = '{1'b0, 1'b0};
  sopw_cmd_t cb [2] = '{8'h00, 8'h00};
  sopw_word_t cd [2] = '{16'h0000, 16'h0000};
  logic wr [2] = '{1'b1, 1'b1};
  sopw_word_t rdi [2] = '{16'h0000, 16'h0F0F};
  sopw_word_t rsp [2] = '{16'h0000, 16'h0000};
  wire cr [2];
  wire rv [2];
  wire ao [2];
  wire cm [2];
  wire wv [2];
  wire sopw_word_t rd [2];
  wire sopw_word_t wd [2];
  wire sopw_cmd_t wc [2];
  wire sopw_cmd_t rc [2];
  int n_errors = 0;
  int n_compared = 0;
  // Free-running system clock
  always #25 CLK_SYS = ~CLK_SYS;
  sopw_link_if lk [2] ();
  // One master and one slave per channel
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    sopw_master #(.BIT_CYC(BIT), .PROG_CYC(100), .PUMP_CYC(50)) i_sopw_master (.CLK_SYS(CLK_SYS), .RST(RST),
      .LINK(lk[i]), .CMD_VALID(cv[i]), .CMD_READY(cr[i]), .CMD_BYTE(cb[i]), .CMD_DATA(cd[i]),
      .RSP_VALID(rv[i]), .RSP_DATA(rd[i]));
    sopw_slave #(.TIMEOUT_CYC(TMO), .TURNON_CYC(TON), .ENTRY_CYC(ENT)) i_sopw_slave (.CLK_SYS(CLK_SYS),
      .RST(RST), .LINK(lk[i]), .ANALOG_OE(ao[i]), .CMD_MODE(cm[i]), .WR_VALID(wv[i]), .WR_READY(wr[i]),
      .WR_CMD(wc[i]), .WR_DATA(wd[i]), .RD_CMD(rc[i]), .RD_DATA(rdi[i]));
  end
  // Checker on the first channel's wire
  sopw_link_monitor #(.BIT_CYC(BIT)) i_sopw_link_monitor (.CLK_SYS(CLK_SYS), .RST(RST),
    .m_drv(lk[0].m_drv), .m_oe(lk[0].m_oe), .s_drv(lk[0].s_drv), .s_oe(lk[0].s_oe), .line(lk[0].line));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One frame on a channel; waits for the master to be idle and, for reads, for the answer
  task automatic xfer(input int ch, input sopw_cmd_t c, input sopw_word_t d);
    int n;
    logic got;
    logic done;
    n = 0;
    got = 1'b0;
    done = 1'b0;
    @(negedge CLK_SYS);
    cb[ch] = c;
    cd[ch] = d;
    cv[ch] = 1'b1;
    while (cr[ch] !== 1'b1)
      @(negedge CLK_SYS);
    @(negedge CLK_SYS);
    cv[ch] = 1'b0;
    while (!done && n < 4000)
    begin
      @(negedge CLK_SYS);
      n++;
      if (rv[ch] === 1'b1)
      begin
        got = 1'b1;
        rsp[ch] = rd[ch];
      end
      done = (cr[ch] === 1'b1) && (got || !c[`SOPW_RW_POS]);
    end
    chk(16'(n >= 4000), 16'h0000, "frame hung");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_up;
    @(negedge CLK_SYS);
    chk(ao[0], 1'b0, "analog during turn-on");
    chk(cm[0], 1'b0, "mode after reset");
    repeat (TON + 2) @(negedge CLK_SYS);
    chk(ao[0], 1'b1, "analog after turn-on");
    chk(ao[1], 1'b1, "analog after turn-on");
  endtask
  // Entry frame on one channel while the other gets a read outside command mode
  task automatic t_entry;
    fork
      xfer(0, `SOPW_ENTRY_CMD, `SOPW_ENTRY_DATA);
      xfer(1, 8'h83, 16'h0000);
    join
    chk(cm[0], 1'b1, "entry taken");
    chk(ao[0], 1'b0, "pin is data line");
    chk(wv[0], 1'b0, "entry frame pushed");
    chk(cm[1], 1'b0, "other channel entered");
    chk(ao[1], 1'b1, "other channel analog");
    chk(rsp[1], 16'hFFFF, "silent slave answered");
  endtask
  // The deaf channel recovers after the idle time-out and then accepts entry
  task automatic t_resync;
    repeat (TMO + 50) @(negedge CLK_SYS);
    xfer(1, `SOPW_ENTRY_CMD, `SOPW_ENTRY_DATA);
    chk(cm[1], 1'b1, "entry after time-out");
    chk(ao[1], 1'b0, "pin is data line");
  endtask
  // Writes with the consumer stalled: reserved region dropped, buffer fills, then drains in order;
  // the memory write is followed by a rewrite of the checksum place
  task automatic t_writes;
    sopw_cmd_t wcmd [3];
    sopw_word_t wdat [3];
    wcmd = '{8'h0A, 8'h84, 8'h1E};
    wdat = '{16'h1234, 16'h8001, 16'h00FF};
    wr[0] = 1'b0;
    xfer(0, 8'h22, 16'hFFFF);
    for (int i = 0; i < 3; i++)
      xfer(0, wcmd[i], wdat[i]);
    for (int i = 0; i < 3; i++)
    begin
      chk(wv[0], 1'b1, "write word waiting");
      chk(wc[0], wcmd[i], "write command");
      chk(wd[0], wdat[i], "write data");
      wr[0] = 1'b1;
      @(negedge CLK_SYS);
      wr[0] = 1'b0;
      repeat (3) @(negedge CLK_SYS);
    end
    chk(wv[0], 1'b0, "buffer empty");
  endtask
  // Reads of register, memory and signature places in command mode
  task automatic t_reads;
    sopw_cmd_t rcmd [3];
    sopw_word_t rval [3];
    rcmd = '{8'h83, 8'h01, 8'h9F};
    rval = '{16'h5AC3, 16'hA53C, 16'hFF00};
    for (int i = 0; i < 3; i++)
    begin
      rdi[0] = rval[i];
      xfer(0, rcmd[i], 16'h0000);
      chk(rc[0], rcmd[i], "read command");
      chk(rsp[0], rval[i], "read word");
      chk(cm[0], 1'b1, "mode kept");
    end
  endtask
  // Power-on reset leaves command mode; entry after the window is refused
  task automatic t_por;
    RST = 1'b1;
    repeat (6) @(negedge CLK_SYS);
    RST = 1'b0;
    chk(cm[0], 1'b0, "mode after reset");
    chk(rc[0], 8'h00, "read command cleared");
    repeat (ENT + 100) @(negedge CLK_SYS);
    xfer(0, `SOPW_ENTRY_CMD, `SOPW_ENTRY_DATA);
    chk(cm[0], 1'b0, "late entry taken");
    chk(ao[0], 1'b1, "analog kept");
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(negedge CLK_SYS);
    RST = 1'b0;
    t_power_up;
    t_entry;
    t_resync;
    t_writes;
    t_reads;
    t_por;
    wrap_up;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge CLK_SYS);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
`default_nettype wire
